// file: core/trip_recovery_pkg.sv
// shared constants and types for the trip auto-recovery controller
package trip_recovery_pkg;
   // register bus geometry
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   // register byte offsets
   localparam logic [7:0]  CTRL_OFS        = 8'h00;
   localparam logic [7:0]  MAX_OFS         = 8'h04;
   localparam logic [7:0]  CAUSE_OFS       = 8'h08;
   localparam logic [7:0]  FIRST_OFS       = 8'h0C;
   localparam logic [7:0]  LATER_OFS       = 8'h10;
   localparam logic [7:0]  STATUS_OFS      = 8'h14;
   localparam logic [7:0]  LEFT_OFS        = 8'h18;
   localparam logic [7:0]  COUNT_OFS       = 8'h1C;
   // control register fields
   localparam int          CTRL_EN_BIT     = 0;
   localparam int          CTRL_MODE_LSB   = 1;
   // status register fields
   localparam int          ST_ACTIVE_BIT   = 0;
   localparam int          ST_PEND_BIT     = 1;
   localparam int          ST_SELFDIS_BIT  = 2;
   localparam int          ST_FAULTED_BIT  = 3;
   localparam int          ST_FLASH_BIT    = 4;
   // field widths
   localparam int          CAUSE_W         = 5;
   localparam int          ATT_W           = 8;
   localparam int          SECS_W          = 16;
   // reset values
   localparam logic [1:0]  MODE_RST        = 2'h0;
   localparam logic [7:0]  MAX_RST         = 8'h05;
   localparam logic [31:0] CAUSE_RST       = 32'h0000_0000;
   localparam logic [15:0] FIRST_RST       = 16'h000A;
   localparam logic [15:0] LATER_RST       = 16'h001E;
   // sequencing control word value that asks for run
   localparam logic [3:0]  RUN_WORD        = 4'hF;
   // timing
   localparam int          CLK_HZ          = 10_000_000;
   localparam int          TICK_CYCLES     = CLK_HZ;        // one second of clock cycles
   localparam int          TRIP_FREE_MIN   = 5;
   localparam logic [15:0] TRIP_FREE_SECS  = 16'(TRIP_FREE_MIN * 60);
   // recovery modes
   typedef enum logic [1:0] {MODE_RESET = 2'h0, MODE_RESTART = 2'h1,
                             MODE_START = 2'h2} mode_t;
   // controller states
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT_CLEAR, ST_DELAY, ST_SELF_DIS} state_t;
endpackage

// file: core/sec_tick_if.sv
// seconds tick carrier between the controller and its prescaler
`timescale 1ns/10ps
interface sec_tick_if;
   logic tick;      // one-cycle pulse per second
   logic restart;   // restarts the second from zero
   modport source (output tick, input restart);
   modport sink   (input tick, output restart);
endinterface

// file: core/sec_prescaler.sv
// prescaler that makes a one-cycle seconds tick from the system clock
`timescale 1ns/10ps
module sec_prescaler
#(
   parameter int TICK_CYCLES = 10_000_000
)
(
   // clock and reset
   input  wire logic   clk,
   input  wire logic   rst_n,
   // tick carrier
   sec_tick_if.source  tk
);
   localparam int     CNT_W = $clog2(TICK_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(TICK_CYCLES - 1);

   logic [CNT_W-1:0]  cnt_q;
   logic [CNT_W-1:0]  cnt_d;
   logic              tick_q;
   logic              tick_d;

   // next count: wrap at one second, restart on request
   always_comb
   begin
      cnt_d  = cnt_q + CNT_W'(1);
      tick_d = 1'b0;
      if (tk.restart)
      begin
         cnt_d = '0;
      end
      else if (cnt_q == LAST)
      begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   // count registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_q  <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tk.tick = tick_q;
endmodule // sec_prescaler

// file: core/trip_auto_recovery.sv
// trip auto-recovery controller with its register port
//
// Contract
// - only selected trip causes start recovery
// - clearing enable disables unit in any state
// - mode 0 resets fault at once, no restart
// - faulted clears after trips inactive and cleared
// - mode 1 delays, then resets and restarts
// - mode 1 no restart if stopped or run dropped
// - mode 1 without restart behaves as mode 0
// - mode 2 starts motor when control word runs
// - pending set when restart will be attempted
// - pending means reset and restart after delay
// - each restart attempt decrements attempts left
// - zero attempts left makes trip self-disable
// - attempts reload after 5 minutes or reset
// - countdown shows delay, starts when trips clear
// - self-disabled until fault cleared otherwise
// - enable low then high leaves self-disable
// - active set when a selected trip occurs
// - run key flashes while restart pending
// - indicators clear on completion or disable
// - first delay when attempts full, else later
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/10ps
module trip_auto_recovery
   import trip_recovery_pkg::*;
#(
   parameter int TICK_CYCLES = trip_recovery_pkg::TICK_CYCLES
)
(
   // clock and reset
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   // register port
   input  wire logic [trip_recovery_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [trip_recovery_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                               reg_wr,
   input  wire logic                               reg_rd,
   output logic      [trip_recovery_pkg::DATA_W-1:0] reg_rdata,
   // trip detection
   input  wire logic                               trip_event,
   input  wire logic [trip_recovery_pkg::CAUSE_W-1:0] trip_cause,
   input  wire logic                               trips_active,
   // sequencing
   input  wire logic                               motor_running,
   input  wire logic                               run_request,
   input  wire logic [3:0]                         control_word,
   input  wire logic                               manual_fault_reset,
   input  wire logic                               keypad_stop,
   output logic                                    fault_reset_req,
   output logic                                    restart_req,
   output logic                                    drive_faulted,
   // indicators
   output logic                                    recovery_active_flag,
   output logic                                    restart_pending_flag,
   output logic                                    run_key_flash,
   output logic      [trip_recovery_pkg::ATT_W-1:0] attempts_left,
   output logic      [trip_recovery_pkg::SECS_W-1:0] delay_countdown
);
   import trip_recovery_pkg::*;

   sec_tick_if tk ();

   // settings
   logic                recovery_enable_q, recovery_enable_d;
   logic [1:0]          recovery_mode_q, recovery_mode_d;
   logic [ATT_W-1:0]    max_attempts_q, max_attempts_d;
   logic [31:0]         trip_cause_select_q, trip_cause_select_d;
   logic [SECS_W-1:0]   first_delay_secs_q, first_delay_secs_d;
   logic [SECS_W-1:0]   later_delay_secs_q, later_delay_secs_d;
   logic [DATA_W-1:0]   rdata_q, rdata_d;
   // recovery state
   state_t              state_q, state_d;
   logic                plan_q, plan_d;        // restart will be attempted
   logic [ATT_W-1:0]    left_q, left_d;
   logic [SECS_W-1:0]   count_q, count_d;
   logic [SECS_W-1:0]   free_q, free_d;        // trip-free seconds
   logic                faulted_q, faulted_d;
   logic                flash_q, flash_d;
   logic                freset_q, freset_d;
   logic                restart_q, restart_d;
   logic                tick_restart;
   logic                selected;
   logic                run_ok;
   logic                pending;

   sec_prescaler #(.TICK_CYCLES(TICK_CYCLES)) u_prescaler
   (
      .clk   (clk),
      .rst_n (rst_n),
      .tk    (tk.source)
   );

   assign selected = trip_event && trip_cause_select_q[trip_cause];
   assign run_ok   = (control_word == RUN_WORD);
   assign pending  = plan_q && (state_q == ST_WAIT_CLEAR || state_q == ST_DELAY);
   assign tk.restart = tick_restart;

   // register writes
   always_comb
   begin
      recovery_enable_d   = recovery_enable_q;
      recovery_mode_d     = recovery_mode_q;
      max_attempts_d      = max_attempts_q;
      trip_cause_select_d = trip_cause_select_q;
      first_delay_secs_d  = first_delay_secs_q;
      later_delay_secs_d  = later_delay_secs_q;
      if (reg_wr)
      begin
         case (reg_addr)
            CTRL_OFS:
            begin
               recovery_enable_d = reg_wdata[CTRL_EN_BIT];
               recovery_mode_d   = reg_wdata[CTRL_MODE_LSB +: 2];
            end
            MAX_OFS:   max_attempts_d      = reg_wdata[ATT_W-1:0];
            CAUSE_OFS: trip_cause_select_d = reg_wdata;
            FIRST_OFS: first_delay_secs_d  = reg_wdata[SECS_W-1:0];
            LATER_OFS: later_delay_secs_d  = reg_wdata[SECS_W-1:0];
            default:   ;
         endcase
      end
   end

   // register reads, answered the cycle after the strobe; unmapped reads zero
   always_comb
   begin
      rdata_d = '0;
      if (reg_rd)
      begin
         case (reg_addr)
            CTRL_OFS:
            begin
               rdata_d[CTRL_EN_BIT]          = recovery_enable_q;
               rdata_d[CTRL_MODE_LSB +: 2]   = recovery_mode_q;
            end
            MAX_OFS:    rdata_d[ATT_W-1:0]  = max_attempts_q;
            CAUSE_OFS:  rdata_d             = trip_cause_select_q;
            FIRST_OFS:  rdata_d[SECS_W-1:0] = first_delay_secs_q;
            LATER_OFS:  rdata_d[SECS_W-1:0] = later_delay_secs_q;
            STATUS_OFS:
            begin
               rdata_d[ST_ACTIVE_BIT]  = recovery_active_flag;
               rdata_d[ST_PEND_BIT]    = pending;
               rdata_d[ST_SELFDIS_BIT] = (state_q == ST_SELF_DIS);
               rdata_d[ST_FAULTED_BIT] = faulted_q;
               rdata_d[ST_FLASH_BIT]   = flash_q;
            end
            LEFT_OFS:   rdata_d[ATT_W-1:0]  = left_q;
            COUNT_OFS:  rdata_d[SECS_W-1:0] = count_q;
            default:    rdata_d = '0;
         endcase
      end
   end

   // recovery sequence
   always_comb
   begin
      state_d      = state_q;
      plan_d       = plan_q;
      left_d       = left_q;
      count_d      = count_q;
      freset_d     = 1'b0;
      restart_d    = 1'b0;
      tick_restart = 1'b0;
      case (state_q)
         ST_IDLE:
         begin
            count_d = '0;
            plan_d  = 1'b0;
            if (selected)
            begin
               if (left_q == '0)
               begin
                  state_d = ST_SELF_DIS;
               end
               else
               begin
                  state_d = ST_WAIT_CLEAR;
                  case (recovery_mode_q)
                     MODE_RESTART: plan_d = motor_running && run_request;
                     MODE_START:   plan_d = 1'b1;
                     default:      plan_d = 1'b0;
                  endcase
               end
            end
         end
         ST_WAIT_CLEAR:
         begin
            if (recovery_mode_q == MODE_RESTART && !run_request)
            begin
               plan_d = 1'b0;
            end
            if (!trips_active)
            begin
               if (plan_d)
               begin
                  state_d      = ST_DELAY;
                  tick_restart = 1'b1;
                  count_d      = (left_q == max_attempts_q) ?
                                 first_delay_secs_q : later_delay_secs_q;
               end
               else
               begin
                  freset_d = 1'b1;
                  state_d  = ST_IDLE;
               end
            end
         end
         ST_DELAY:
         begin
            if (recovery_mode_q == MODE_RESTART && !run_request)
            begin
               plan_d = 1'b0;
            end
            if (trips_active)
            begin
               state_d = ST_WAIT_CLEAR;
               count_d = '0;
            end
            else if (!plan_d)
            begin
               freset_d = 1'b1;
               state_d  = ST_IDLE;
               count_d  = '0;
            end
            else if (count_q == '0)
            begin
               freset_d  = 1'b1;
               restart_d = (recovery_mode_q != MODE_START) || run_ok;
               left_d    = left_q - ATT_W'(1);
               state_d   = ST_IDLE;
            end
            else if (tk.tick)
            begin
               count_d = count_q - SECS_W'(1);
            end
         end
         ST_SELF_DIS:
         begin
            plan_d = 1'b0;
            if (manual_fault_reset || keypad_stop)
            begin
               state_d = ST_IDLE;
            end
         end
         default:
         begin
            state_d = ST_IDLE;
         end
      endcase
      // trip-free time or an outside reset refills the attempts
      if (manual_fault_reset || (free_q >= TRIP_FREE_SECS))
      begin
         left_d = max_attempts_q;
      end
      // disabling overrides state, plan, countdown and requests and clears the indicators; attempts left still update
      if (!recovery_enable_q)
      begin
         state_d   = ST_IDLE;
         plan_d    = 1'b0;
         count_d   = '0;
         freset_d  = 1'b0;
         restart_d = 1'b0;
      end
   end

   // trip-free timer, faulted bit and run-key flashing
   always_comb
   begin
      free_d    = free_q;
      faulted_d = faulted_q;
      flash_d   = 1'b0;
      if (trip_event || trips_active || faulted_q)
      begin
         free_d = '0;
      end
      else if (tk.tick && free_q < TRIP_FREE_SECS)
      begin
         free_d = free_q + SECS_W'(1);
      end
      // cleared only with trips inactive and a reset taken; a new trip wins
      if ((freset_q || manual_fault_reset || keypad_stop) && !trips_active)
      begin
         faulted_d = 1'b0;
      end
      if (trip_event)
      begin
         faulted_d = 1'b1;
      end
      if (pending)
      begin
         flash_d = tk.tick ? !flash_q : flash_q;
      end
   end

   // registers
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         recovery_enable_q   <= 1'b0;
         recovery_mode_q     <= MODE_RST;
         max_attempts_q      <= MAX_RST;
         trip_cause_select_q <= CAUSE_RST;
         first_delay_secs_q  <= FIRST_RST;
         later_delay_secs_q  <= LATER_RST;
         rdata_q             <= '0;
         state_q             <= ST_IDLE;
         plan_q              <= 1'b0;
         left_q              <= MAX_RST;
         count_q             <= '0;
         free_q              <= '0;
         faulted_q           <= 1'b0;
         flash_q             <= 1'b0;
         freset_q            <= 1'b0;
         restart_q           <= 1'b0;
      end
      else
      begin
         recovery_enable_q   <= recovery_enable_d;
         recovery_mode_q     <= recovery_mode_d;
         max_attempts_q      <= max_attempts_d;
         trip_cause_select_q <= trip_cause_select_d;
         first_delay_secs_q  <= first_delay_secs_d;
         later_delay_secs_q  <= later_delay_secs_d;
         rdata_q             <= rdata_d;
         state_q             <= state_d;
         plan_q              <= plan_d;
         left_q              <= left_d;
         count_q             <= count_d;
         free_q              <= free_d;
         faulted_q           <= faulted_d;
         flash_q             <= flash_d;
         freset_q            <= freset_d;
         restart_q           <= restart_d;
      end
   end

   // outputs
   assign reg_rdata            = rdata_q;
   assign fault_reset_req      = freset_q;
   assign restart_req          = restart_q;
   assign drive_faulted        = faulted_q;
   assign recovery_active_flag = (state_q == ST_WAIT_CLEAR) || (state_q == ST_DELAY);
   assign restart_pending_flag = pending;
   assign run_key_flash        = flash_q;
   assign attempts_left        = left_q;
   assign delay_countdown      = count_q;
endmodule // trip_auto_recovery

// file: verification/drive_model.sv
// behavioural trip detection and run sequencing partner of the controller
`timescale 1ns/10ps
module drive_model
(
   // clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst_n,
   // bench commands
   input  wire logic                                trip_go,
   input  wire logic [trip_recovery_pkg::CAUSE_W-1:0] trip_go_cause,
   input  wire logic                                trip_off,
   input  wire logic                                motor_go,
   // controller request
   input  wire logic                                restart_req,
   // trip detection and motor state
   output logic                                     trip_event,
   output logic      [trip_recovery_pkg::CAUSE_W-1:0] trip_cause,
   output logic                                     trips_active,
   output logic                                     motor_running
);
   import trip_recovery_pkg::*;
   // trip pulse, held trip source and motor state
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         trip_event    <= 1'b0;
         trip_cause    <= 5'h00;
         trips_active  <= 1'b0;
         motor_running <= 1'b0;
      end
      else
      begin
         trip_event <= trip_go;
         trip_cause <= trip_go ? trip_go_cause : ~trip_cause; // cause not held after pulse
         if (trip_go)
            trips_active <= 1'b1;
         else if (trip_off)
            trips_active <= 1'b0;
         if (trip_event)
            motor_running <= 1'b0; // motor coasts once tripped
         else if (restart_req || motor_go)
            motor_running <= 1'b1;
      end
   end
endmodule // drive_model

// file: verification/trip_recovery_props.sv
// port assertions for the trip auto-recovery controller
`timescale 1ns/10ps
module trip_recovery_props
(
   // clock and reset
   input wire logic                                 clk,
   input wire logic                                 rst_n,
   // trip and reset inputs
   input wire logic                                 trip_event,
   input wire logic                                 trips_active,
   input wire logic                                 manual_fault_reset,
   input wire logic                                 keypad_stop,
   // requests and indicators
   input wire logic                                 fault_reset_req,
   input wire logic                                 restart_req,
   input wire logic                                 drive_faulted,
   input wire logic                                 recovery_active_flag,
   input wire logic                                 restart_pending_flag,
   input wire logic                                 run_key_flash,
   input wire logic [trip_recovery_pkg::SECS_W-1:0] delay_countdown
);
   import trip_recovery_pkg::*;
   // one clock domain for all checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   a_restart_pairs: assert property (restart_req |-> fault_reset_req)
      else $error("restart without fault reset");
   a_restart_planned: assert property (restart_req |-> $past(restart_pending_flag))
      else $error("restart not announced as pending");
   a_pending_active: assert property (restart_pending_flag |-> recovery_active_flag)
      else $error("pending while not active");
   a_flash_pending: assert property (!restart_pending_flag && !$past(restart_pending_flag)
      |-> !run_key_flash)
      else $error("run key flashing with nothing pending");
   a_done_clears: assert property (fault_reset_req |-> !recovery_active_flag
      && !restart_pending_flag)
      else $error("indicators stand after the attempt");
   a_reset_after_clear: assert property (fault_reset_req |-> !$past(trips_active))
      else $error("fault reset while trips active");
   a_trip_faults: assert property (trip_event |=> drive_faulted)
      else $error("trip did not set faulted");
   a_fault_clear_cause: assert property ($fell(drive_faulted) |-> $past(!trips_active
      && (fault_reset_req || manual_fault_reset || keypad_stop)))
      else $error("faulted cleared without a reset");
   a_count_idle: assert property (!recovery_active_flag |-> delay_countdown == 16'h0000)
      else $error("countdown running while idle");
   a_trip_stops_count: assert property (trips_active |=> delay_countdown == 16'h0000)
      else $error("countdown running while tripped");
   a_count_steps: assert property ($past(delay_countdown) != 16'h0000
      && delay_countdown != $past(delay_countdown) |-> (delay_countdown == 16'h0000
      || delay_countdown == $past(delay_countdown) - 16'h0001))
      else $error("countdown skipped a second");
endmodule // trip_recovery_props

bind trip_auto_recovery trip_recovery_props chk_u (.*);

// file: verification/tb_top.sv
// self-checking bench for the trip auto-recovery controller
`timescale 1ns/10ps
module tb_top;
   import trip_recovery_pkg::*;
   localparam int TK = 10; // cycles in one shortened second
   // bench drive
   logic               clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [ADDR_W-1:0]  reg_addr = 8'h00;
   logic [DATA_W-1:0]  reg_wdata = 32'h0, rd_q;
   logic               trip_go = 1'b0, trip_off = 1'b0, motor_go = 1'b0, run_request = 1'b0;
   logic               manual_fault_reset = 1'b0, keypad_stop = 1'b0;
   logic [CAUSE_W-1:0] go_cause = 5'h00;
   logic [3:0]         control_word = 4'h0;
   // design and partner outputs
   logic [DATA_W-1:0]  reg_rdata;
   logic [CAUSE_W-1:0] trip_cause;
   logic               trip_event, trips_active, motor_running, fault_reset_req, restart_req;
   logic               drive_faulted, recovery_active_flag, restart_pending_flag, run_key_flash;
   logic [ATT_W-1:0]   attempts_left;
   logic [SECS_W-1:0]  delay_countdown;
   logic               saw_flash, saw_restart;
   int                 err_count = 0, check_count = 0, waited;
   // clock
   always #50 clk = ~clk;
   // controller with a shortened second
   trip_auto_recovery #(.TICK_CYCLES(TK)) dut_u (.*);
   // trip detection and motor partner
   drive_model model_u (.*, .trip_go_cause(go_cause));
   // verdict and end of run
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // value compare
   task automatic chk(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
      check_count++;
      if (g !== e)
      begin
         err_count++;
         $display("ERROR at %0t: got %0h expected %0h", $time, g, e);
      end
   endtask
   // bus and pin helpers
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic sd(input logic e);
      rd(STATUS_OFS, rd_q);
      chk(rd_q[ST_SELFDIS_BIT], e);
   endtask
   task automatic trip(input logic [CAUSE_W-1:0] c);
      @(posedge clk);
      trip_go <= 1'b1;
      go_cause <= c;
      @(posedge clk);
      trip_go <= 1'b0;
      cyc(2);
   endtask
   task automatic clear();
      @(posedge clk);
      trip_off <= 1'b1;
      @(posedge clk);
      trip_off <= 1'b0;
   endtask
   task automatic kick(input int stop);
      @(posedge clk);
      if (stop != 0)
         keypad_stop <= 1'b1;
      else
         manual_fault_reset <= 1'b1;
      @(posedge clk);
      keypad_stop <= 1'b0;
      manual_fault_reset <= 1'b0;
      cyc(1);
   endtask
   // bounded wait for the fault reset pulse
   task automatic wait_req(input int n);
      waited = 0;
      saw_flash = 1'b0;
      while (fault_reset_req !== 1'b1)
      begin
         cyc(1);
         waited++;
         if (run_key_flash === 1'b1)
            saw_flash = 1'b1;
         if (waited > n)
         begin
            err_count++;
            $display("ERROR at %0t: no fault reset request", $time);
            test_done();
         end
      end
      saw_restart = restart_req;
   endtask
   // register reset values, read-only and unmapped places
   task automatic t_regs();
      logic [7:0]  ofs [9] = '{CTRL_OFS, 8'h20, CAUSE_OFS, FIRST_OFS, LATER_OFS,
                               STATUS_OFS, LEFT_OFS, COUNT_OFS, MAX_OFS};
      logic [31:0] ev [9] = '{32'h0, 32'h0, 32'h0, 32'hA, 32'h1E, 32'h0, 32'h5, 32'h0, 32'h5};
      wr(LEFT_OFS, 32'h0000_0009);
      for (int i = 0; i < 9; i++)
      begin
         rd(ofs[i], rd_q);
         chk(rd_q, ev[i]);
      end
      cyc(1);
      chk(reg_rdata, 32'h0);
      $display("test regs done");
   endtask
   // mode 0: unselected and selected causes
   task automatic t_mode0();
      wr(CAUSE_OFS, 32'h0000_0008);
      wr(CTRL_OFS, 32'h1);
      trip(5'h02);
      chk(recovery_active_flag, 1'b0);
      clear();
      kick(1);
      trip(5'h03);
      chk(recovery_active_flag, 1'b1);
      clear();
      wait_req(4);
      chk(saw_restart, 1'b0);
      cyc(2);
      chk(drive_faulted, 1'b0);
      chk(attempts_left, 8'h05);
      $display("test mode0 done");
   endtask
   // mode 1: delays, retrip during delay, restart
   task automatic t_mode1();
      wr(FIRST_OFS, 32'h2);
      wr(LATER_OFS, 32'h1);
      wr(CTRL_OFS, 32'h3);
      @(posedge clk);
      motor_go <= 1'b1;
      run_request <= 1'b1;
      @(posedge clk);
      motor_go <= 1'b0;
      trip(5'h03);
      chk(restart_pending_flag, 1'b1);
      clear();
      cyc(2);
      chk(delay_countdown, 16'h2);
      trip(5'h03);
      chk(recovery_active_flag, 1'b1);
      chk(delay_countdown, 16'h0);
      clear();
      wait_req(4 * TK);
      chk(saw_restart, 1'b1);
      chk(waited >= 2 * TK, 1'b1);
      chk(saw_flash, 1'b1);
      cyc(1);
      chk(attempts_left, 8'h04);
      trip(5'h03);
      clear();
      cyc(2);
      chk(delay_countdown, 16'h1);
      wait_req(4 * TK);
      cyc(1);
      chk(attempts_left, 8'h03);
      $display("test mode1 done");
   endtask
   // mode 1: run dropped after trip, motor stopped at trip
   task automatic t_drop();
      trip(5'h03);
      @(posedge clk);
      run_request <= 1'b0;
      @(posedge clk);
      run_request <= 1'b1;
      cyc(1);
      chk(restart_pending_flag, 1'b0);
      clear();
      wait_req(4);
      chk(saw_restart, 1'b0);
      trip(5'h03);
      chk(restart_pending_flag, 1'b0);
      clear();
      wait_req(4);
      cyc(1);
      chk(attempts_left, 8'h03);
      $display("test drop done");
   endtask
   // mode 2: start a stopped motor when the control word runs
   task automatic t_mode2();
      wr(CTRL_OFS, 32'h5);
      control_word <= 4'hF;
      trip(5'h03);
      chk(restart_pending_flag, 1'b1);
      clear();
      wait_req(4 * TK);
      chk(saw_restart, 1'b1);
      cyc(1);
      chk(attempts_left, 8'h02);
      $display("test mode2 done");
   endtask
   // reload, exhaustion and leaving self-disable
   task automatic t_exhaust();
      wr(MAX_OFS, 32'h1);
      kick(0);
      chk(attempts_left, 8'h01);
      for (int i = 0; i < 2; i++)
      begin
         trip(5'h03);
         clear();
         wait_req(4 * TK);
         chk(saw_restart, !i[0]);
         cyc(1);
         chk(attempts_left, 8'h00);
         if (i == 0)
         begin
            cyc(290 * TK);
            chk(attempts_left, 8'h00);
            cyc(20 * TK);
            chk(attempts_left, 8'h01);
            @(posedge clk);
            control_word <= 4'h0; // next attempt may not start the motor
         end
      end
      trip(5'h03);
      sd(1'b1);
      chk(recovery_active_flag, 1'b0);
      clear();
      kick(1);
      sd(1'b0);
      trip(5'h03);
      sd(1'b1);
      clear();
      wr(CTRL_OFS, 32'h4);
      wr(CTRL_OFS, 32'h5);
      sd(1'b0);
      $display("test exhaust done");
   endtask
   // enable cleared in mid-delay
   task automatic t_disable();
      kick(0);
      trip(5'h03);
      clear();
      cyc(3);
      chk(delay_countdown, 16'h2);
      wr(CTRL_OFS, 32'h4);
      cyc(1);
      chk(recovery_active_flag, 1'b0);
      chk(restart_pending_flag, 1'b0);
      chk(delay_countdown, 16'h0);
      $display("test disable done");
   endtask
   // reset, then the scenarios in turn
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_mode0();
      t_mode1();
      t_drop();
      t_mode2();
      t_exhaust();
      t_disable();
      test_done();
   end
endmodule // tb_top
